// ### dv/array_model.sv
`timescale 1ns/10ps
`include "bist_params.svh"
// Behavioural arrays behind the dispatch unit, one word per address
module array_model (
    input wire logic clk_sys_in,
    input wire logic any_cs_in,
    input wire logic write_in,
    input wire logic [`XLAT_W-1:0] write_data_in,
    input wire logic [`X_W-1:0] xaddr_in,
    input wire logic [`Y_W-1:0] yaddr_in,
    input wire logic fault_in,
    output logic [`DATA_W-1:0] cache_data_out,
    output logic [`XLAT_W-1:0] array_data_out
);
    logic [`XLAT_W-1:0] store [logic [22:0]];
    logic [22:0] key;
    assign key = {xaddr_in, yaddr_in};
    assign cache_data_out = array_data_out[`DATA_W-1:0];
    initial array_data_out = '0;
    // Unselected arrays show a toggling pattern, never a stale word
    always @(posedge clk_sys_in) begin
        if (any_cs_in && write_in) begin
            store[key] = write_data_in;
        end
        if (any_cs_in && !write_in) begin
            array_data_out <= (store.exists(key) ? store[key] : '0) ^ {`XLAT_W{fault_in}};
        end else begin
            array_data_out <= ~array_data_out;
        end
    end
endmodule : array_model

// ### dv/tb_top.sv
`timescale 1ns/10ps
`include "bist_params.svh"
module tb_top;
    import bist_pkg::*;
    logic clk_sys_in, reset_in, gate, ishift, dshift, sin, byp, se, fault, any_cs;
    logic [10:0] cmd;
    logic [63:0] crd_in, crd_out;
    logic [112:0] ard_in, wdata;
    logic [2:0] rx_c, rx_t, status;
    logic [3:0] icd, dcd, ict, dct;
    logic icv, dvd, xcs, tset, wr, expire_seen, fail_seen;
    logic [1:0] itc, dtc;
    logic [10:0] xa;
    logic [11:0] ya;
    int failures, samples_checked, pulses;
    assign any_cs = |{icd, dcd, ict, dct, icv, dvd, xcs, itc, dtc};
    // Coupled-memory arrays left unconnected so their masking shows
    memory_bist_dispatch_unit #(.CONNECTED(10'h0ff)) u_dut (.clk_sys_in(clk_sys_in),
        .reset_in(reset_in), .test_clock_gate_in(gate), .controller_command_bus_in(cmd),
        .instruction_shift_in(ishift), .datalog_shift_in(dshift), .serial_test_in(sin),
        .ram_bypass_select_in(byp), .scan_shift_enable_in(se), .cache_read_data_in(crd_in),
        .array_read_data_in(ard_in), .cache_read_data_out(crd_out),
        .cache_unit_return_bus_out(rx_c), .tcm_unit_return_bus_out(rx_t),
        .test_status_out(status), .icache_data_cs_out(icd), .dcache_data_cs_out(dcd),
        .icache_tag_cs_out(ict), .dcache_tag_cs_out(dct), .icache_valid_cs_out(icv),
        .dcache_vd_cs_out(dvd), .xlat_cs_out(xcs), .itcm_cs_out(itc), .dtcm_cs_out(dtc),
        .tag_set_out(tset), .write_out(wr), .write_data_out(wdata), .xaddr_out(xa),
        .yaddr_out(ya));
    array_model u_arrays (.clk_sys_in(clk_sys_in), .any_cs_in(any_cs), .write_in(wr),
        .write_data_in(wdata), .xaddr_in(xa), .yaddr_in(ya), .fault_in(fault),
        .cache_data_out(crd_in), .array_data_out(ard_in));
    initial begin
        clk_sys_in = 1'h0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    task automatic step();
        @(posedge clk_sys_in);
        #1;
    endtask : step
    task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    // Instruction enters LSB first on the address-increment line
    task automatic shift_instr(input logic [31:0] v);
        ishift = 1'h1;
        for (int i = 0; i < 32; i++) begin
            cmd = {9'h0, v[i], 1'h0};
            step();
        end
        ishift = 1'h0;
        cmd = 11'h0;
        step();
    endtask : shift_instr
    // One march element in y-fast order until completion is reported
    task automatic run_pass(input logic [10:0] op, input logic probe, input logic inject);
        int i;
        i = 0;
        expire_seen = 1'h0;
        fail_seen = 1'h0;
        pulses = 0;
        cmd = 11'h081;
        step();
        while (status[1] !== 1'h1 && i < 6000) begin
            cmd = op | 11'h082;
            fault = inject && i == 500;
            if (probe && i == 50) begin
                check("cs_active", 1'h1, any_cs);
                check("tcm_masked", 1'h0, {rx_t, itc, dtc});
            end
            if (probe && i == 100) begin
                se = 1'h1;
                #1;
                check("cs_in_scan", 1'h0, {wr, any_cs});
            end
            step();
            se = 1'h0;
            expire_seen |= status[0];
            fail_seen |= rx_c[2];
            pulses += status[2];
            i++;
        end
        cmd = 11'h0;
        fault = 1'h0;
        if (i >= 6000) begin
            failures++;
            conclude();
        end
    endtask : run_pass
    task automatic reset_state();
        check("idle_outputs", 1'h0, {status, rx_c, rx_t, any_cs, wr});
    endtask : reset_state
    task automatic bypass_path();
        step();
        check("read_path", crd_in, crd_out);
        byp = 1'h1;
        #1;
        check("bypass_path", 64'h0, crd_out);
    endtask : bypass_path
    task automatic no_enable_start();
        shift_instr(32'h0);
        cmd = 11'h081;
        repeat (3) step();
        cmd = 11'h0;
        check("done_refused", 1'h0, status[1]);
        check("rx_masked", 1'h0, {rx_c, rx_t});
    endtask : no_enable_start
    task automatic write_pass();
        shift_instr(32'h0000_03ff);
        run_pass(11'h020, 1'h1, 1'h0);
        check("expire_seen", 1'h1, expire_seen);
        check("write_fail", 1'h0, status[2]);
    endtask : write_pass
    // Sticky mode keeps the flag after one bad compare
    task automatic sticky_read();
        shift_instr(32'h0000_03ff);
        run_pass(11'h040, 1'h0, 1'h1);
        check("sticky_fail", 1'h1, status[2]);
        check("done_level", 1'h1, status[1]);
        check("rx_fail", 1'h1, fail_seen);
    endtask : sticky_read
    task automatic pulse_read();
        shift_instr(32'h0000_83ff);
        run_pass(11'h040, 1'h0, 1'h1);
        check("fail_pulses", 32'h1, pulses);
        check("fail_after", 1'h0, status[2]);
    endtask : pulse_read
    initial begin
        reset_in = 1'h1;
        gate = 1'h1;
        {ishift, dshift, sin, byp, se, fault} = 6'h0;
        cmd = 11'h0;
        failures = 0;
        samples_checked = 0;
        repeat (12) @(posedge clk_sys_in);
        #1;
        reset_in = 1'h0;
        reset_state();
        bypass_path();
        no_enable_start();
        write_pass();
        sticky_read();
        pulse_read();
        conclude();
    end
endmodule : tb_top

// ### verilog/addr_scramble.sv
`timescale 1ns/10ps
`include "bist_params.svh"
// Address scramble and chip-select gating for one dispatch unit.
module addr_scramble (
    input wire logic [`X_W-1:0] xaddr_in,
    input wire logic [`Y_W-1:0] yaddr_in,
    input wire logic [`ENABLE_W-1:0] enables_in,
    input wire logic access_in,
    input wire logic scan_shift_enable_in,
    output logic [3:0] icache_data_cs_out,
    output logic [3:0] dcache_data_cs_out,
    output logic [3:0] icache_tag_cs_out,
    output logic [3:0] dcache_tag_cs_out,
    output logic icache_valid_cs_out,
    output logic dcache_vd_cs_out,
    output logic xlat_cs_out,
    output logic [1:0] itcm_cs_out,
    output logic [1:0] dtcm_cs_out,
    output logic tag_set_out
);
    // Out of bounds: true when the index lies beyond the array's rows/columns
    function automatic logic outside(input logic [`X_W-1:0] x, input logic [`Y_W-1:0] y,
                                     input int xb, input int yb);
        logic o;
        o = 1'b0;
        for (int i = 0; i < `X_W; i++) if (i >= xb && x[i]) o = 1'b1;
        for (int i = 0; i < `Y_W; i++) if (i >= yb && y[i]) o = 1'b1;
        return o;
    endfunction : outside

    // Bank select decode from the two highest column bits inside the index
    function automatic logic [3:0] bank(input logic [1:0] b);
        return 4'h1 << b;
    endfunction : bank

    wire live = access_in & ~scan_shift_enable_in;
    wire out_cdata = outside(xaddr_in, yaddr_in, 8, 6);
    wire out_tag = outside(xaddr_in, yaddr_in, 8, 5);
    wire out_valid = outside(xaddr_in, yaddr_in, 8, 3);
    wire out_dirty = outside(xaddr_in, yaddr_in, 8, 2);
    wire out_xlat = outside(xaddr_in, yaddr_in, 7, 0);
    wire out_tcm = outside(xaddr_in, yaddr_in, 8, 11);

    // Data and tag banks sit on column bits, gated by the master select
    assign icache_data_cs_out = {4{live & enables_in[`EN_ICDATA] & ~out_cdata}}
                                & bank(yaddr_in[5:4]);
    assign dcache_data_cs_out = {4{live & enables_in[`EN_DCDATA] & ~out_cdata}}
                                & bank(yaddr_in[5:4]);
    assign icache_tag_cs_out = {4{live & enables_in[`EN_ICTAG] & ~out_tag}}
                               & bank(yaddr_in[4:3]);
    assign dcache_tag_cs_out = {4{live & enables_in[`EN_DCTAG] & ~out_tag}}
                               & bank(yaddr_in[4:3]);
    // Valid and dirty share one select
    assign icache_valid_cs_out = live & enables_in[`EN_ICVALID] & ~out_valid;
    assign dcache_vd_cs_out = live & ~out_valid & (enables_in[`EN_DCVALID]
                              | (enables_in[`EN_DCDIRTY] & ~out_dirty));
    assign xlat_cs_out = live & enables_in[`EN_XLAT] & ~out_xlat;
    // Coupled memory implementation selects on upper bits, gated by field 9:8
    wire [1:0] tcm_half = {yaddr_in[10], ~yaddr_in[10]}; // Upper bit picks the half
    assign itcm_cs_out = {2{live & enables_in[`EN_ITCM] & ~out_tcm}} & tcm_half;
    assign dtcm_cs_out = {2{live & enables_in[`EN_DTCM] & ~out_tcm}} & tcm_half;
    assign tag_set_out = xaddr_in[`TAG_SET_BIT-8];
endmodule : addr_scramble

// ### verilog/bist_params.svh
`ifndef BIST_PARAMS_SVH
`define BIST_PARAMS_SVH
// Command bus bit positions
`define CMD_ADDR_RESET 0
`define CMD_ADDR_INC 1
`define CMD_INVERT 3
`define CMD_CHECKER 4
`define CMD_WRITE 5
`define CMD_READ 6
`define CMD_YFAST 7
`define CMD_BITMAP 9
// Return bus bit positions
`define RET_EXPIRE 0
`define RET_STALL 1
`define RET_FAIL 2
// Instruction register layout
`define INSTR_LEN 32
`define ENABLE_LSB 0
`define ENABLE_W 10
`define ENG_PULSE_FAIL 15
`define OP_LSB 16
`define OP_W 4
`define MAXX_LSB 20
`define MAXY_LSB 26
`define ADDR_FIELD_W 6
// Opcode of the read-fail-log instruction, other codes run a test
`define OP_READ_LOG 4'h1
// Array dimensions
`define X_W 11
`define Y_W 12
`define MIN_LOCATIONS 8
`define DATA_W 64
`define TAG_W 22
`define VALID_W 24
`define DIRTY_W 8
`define XLAT_W 113
`define XLAT_ENTRIES 128
`define TAG_SET_BIT 12
`define TCM_CS_HI 9
`define TCM_CS_LO 8
// Fail log widths
`define LOG_W 128
`define CS_W 4
`define EXP_W 4
// Array enable bits
`define EN_ICDATA 0
`define EN_ICTAG 1
`define EN_ICVALID 2
`define EN_DCDATA 3
`define EN_DCTAG 4
`define EN_DCVALID 5
`define EN_DCDIRTY 6
`define EN_XLAT 7
`define EN_ITCM 8
`define EN_DTCM 9
`endif

// ### verilog/bist_pkg.sv
package bist_pkg;
    typedef enum logic [1:0] {
        st_idle,
        st_run,
        st_stall,
        st_done
    } dispatch_state_type;
endpackage : bist_pkg

// ### verilog/memory_bist_dispatch_unit.sv
`timescale 1ns/10ps
`include "bist_params.svh"
module memory_bist_dispatch_unit
    import bist_pkg::*;
#(
    parameter logic [`ENABLE_W-1:0] CONNECTED = 10'h3ff
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic test_clock_gate_in,
    input wire logic [10:0] controller_command_bus_in,
    input wire logic instruction_shift_in,
    input wire logic datalog_shift_in,
    input wire logic serial_test_in,
    input wire logic ram_bypass_select_in,
    input wire logic scan_shift_enable_in,
    input wire logic [`DATA_W-1:0] cache_read_data_in,
    input wire logic [`XLAT_W-1:0] array_read_data_in,
    output logic [`DATA_W-1:0] cache_read_data_out,
    output logic [2:0] cache_unit_return_bus_out,
    output logic [2:0] tcm_unit_return_bus_out,
    output logic [2:0] test_status_out,
    output logic [3:0] icache_data_cs_out,
    output logic [3:0] dcache_data_cs_out,
    output logic [3:0] icache_tag_cs_out,
    output logic [3:0] dcache_tag_cs_out,
    output logic icache_valid_cs_out,
    output logic dcache_vd_cs_out,
    output logic xlat_cs_out,
    output logic [1:0] itcm_cs_out,
    output logic [1:0] dtcm_cs_out,
    output logic tag_set_out,
    output logic write_out,
    output logic [`XLAT_W-1:0] write_data_out,
    output logic [`X_W-1:0] xaddr_out,
    output logic [`Y_W-1:0] yaddr_out
);
    dispatch_state_type state;
    dispatch_state_type next_state;
    logic [`INSTR_LEN-1:0] instr;
    logic [`X_W-1:0] xaddr;
    logic [`Y_W-1:0] yaddr;
    logic [`ENABLE_W-1:0] fail_bits;
    logic [`LOG_W+`CS_W+`EXP_W+17-1:0] log_sr;
    logic logged;
    logic read_pend;
    logic fail_pulse;
    logic fail_sticky;
    logic expired;
    logic [`XLAT_W-1:0] compare_reg;
    logic log_mode;
    logic dshift_d;

    // Decode of the instruction fields
    wire [`ENABLE_W-1:0] enables = instr[`ENABLE_LSB +: `ENABLE_W] & CONNECTED;
    wire [`OP_W-1:0] opcode = instr[`OP_LSB +: `OP_W];
    wire pulse_mode = instr[`ENG_PULSE_FAIL];
    wire [`X_W-1:0] max_x = {instr[`MAXX_LSB +: `ADDR_FIELD_W], 5'h1f};
    wire [`Y_W-1:0] max_y = {instr[`MAXY_LSB +: `ADDR_FIELD_W], 6'h3f};
    wire step = test_clock_gate_in;
    wire [10:0] cmd = controller_command_bus_in;
    wire x_exp = (xaddr == max_x);
    wire y_exp = (yaddr == max_y);
    wire both_exp = x_exp & y_exp;
    // Arrays need eight locations; a degenerate bound never starts a run
    wire big_enough = (32'(max_x) + 1) * (32'(max_y) + 1) >= `MIN_LOCATIONS;
    wire running = (state == st_run);
    wire bitmap = cmd[`CMD_BITMAP];
    wire do_read = running & step & cmd[`CMD_READ];

    // Expected word from the background pattern controls
    wire exp_bit = cmd[`CMD_INVERT] ^ (cmd[`CMD_CHECKER] & (xaddr[0] ^ yaddr[0]));
    wire [`XLAT_W-1:0] expect_word = {`XLAT_W{exp_bit}};
    wire [`XLAT_W-1:0] mask = array_read_data_in ^ expect_word;
    wire miscompare = read_pend & (|mask);

    // Compare register doubles as scan observe point, bypass muxes it in
    assign cache_read_data_out = ram_bypass_select_in ? compare_reg[`DATA_W-1:0]
                                 : cache_read_data_in;

    addr_scramble scramble (
        .xaddr_in(xaddr),
        .yaddr_in(yaddr),
        .enables_in(enables),
        .access_in(running & step & (cmd[`CMD_READ] | cmd[`CMD_WRITE])),
        .scan_shift_enable_in(scan_shift_enable_in),
        .icache_data_cs_out(icache_data_cs_out),
        .dcache_data_cs_out(dcache_data_cs_out),
        .icache_tag_cs_out(icache_tag_cs_out),
        .dcache_tag_cs_out(dcache_tag_cs_out),
        .icache_valid_cs_out(icache_valid_cs_out),
        .dcache_vd_cs_out(dcache_vd_cs_out),
        .xlat_cs_out(xlat_cs_out),
        .itcm_cs_out(itcm_cs_out),
        .dtcm_cs_out(dtcm_cs_out),
        .tag_set_out(tag_set_out)
    );

    assign write_out = running & step & cmd[`CMD_WRITE] & ~scan_shift_enable_in;
    assign write_data_out = expect_word;
    assign xaddr_out = xaddr;
    assign yaddr_out = yaddr;

    // Build the log image for the first enabled array in priority order, select first for data and tag arrays
    function automatic logic [`LOG_W+`CS_W+`EXP_W+17-1:0] pack_log(
        input logic [`ENABLE_W-1:0] en, input logic [3:0] cs, input logic [3:0] ex,
        input logic [`X_W-1:0] x, input logic [`Y_W-1:0] y, input logic [`XLAT_W-1:0] m);
        logic [`LOG_W+`CS_W+`EXP_W+17-1:0] v;
        v = '0;
        if (en[`EN_ICDATA] | en[`EN_DCDATA])
            v[83:0] = {m[63:0], x[7:0], y[3:0], ex, cs};
        else if (en[`EN_ICTAG] | en[`EN_DCTAG])
            v[40:0] = {m[21:0], x[7:0], y[2:0], ex, cs};
        else if (en[`EN_ICVALID] | en[`EN_DCVALID])
            v[35:0] = {m[23:0], x[7:0], ex};
        else if (en[`EN_DCDIRTY])
            v[21:0] = {m[7:0], x[7:0], y[1:0], ex};
        else if (en[`EN_XLAT])
            v[121:0] = {m[112:0], x[4:0], ex};
        else
            v[84:0] = {m[63:0], y[8:3], x[7:0], y[2:0], ex};
        return v;
    endfunction : pack_log

    // Controller steering
    always_comb begin
        next_state = state;
        case (state)
            st_idle: if (step && cmd[`CMD_ADDR_RESET] && !instruction_shift_in
                         && big_enough && opcode != `OP_READ_LOG && |enables)
                next_state = st_run;
            st_run: if (step && both_exp && cmd[`CMD_ADDR_INC] && cmd[`CMD_YFAST])
                next_state = st_done;
            else if (do_read && bitmap)
                next_state = st_stall;
            st_stall: if (!read_pend && !logged)
                next_state = st_run;
            st_done: if (step && instruction_shift_in)
                next_state = st_idle;
            default: next_state = st_idle;
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) state <= st_idle;
        else state <= next_state;
    end

    // Row/column counters, stepped only on gated edges
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            xaddr <= '0;
            yaddr <= '0;
        end else if (step && !instruction_shift_in) begin
            if (cmd[`CMD_ADDR_RESET]) begin
                xaddr <= '0;
                yaddr <= '0;
            end else if (running && cmd[`CMD_ADDR_INC]) begin
                if (cmd[`CMD_YFAST]) begin
                    yaddr <= y_exp ? '0 : yaddr + 1'b1;
                    if (y_exp) xaddr <= x_exp ? '0 : xaddr + 1'b1;
                end else begin
                    xaddr <= x_exp ? '0 : xaddr + 1'b1;
                    if (x_exp) yaddr <= y_exp ? '0 : yaddr + 1'b1;
                end
            end
        end
    end

    // Read compare, logging and fail flags
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            read_pend <= 1'b0;
            compare_reg <= '0;
            fail_bits <= '0;
            fail_pulse <= 1'b0;
            fail_sticky <= 1'b0;
            logged <= 1'b0;
            log_sr <= '0;
            expired <= 1'b0;
            dshift_d <= 1'b0;
        end else begin
            dshift_d <= datalog_shift_in;
            read_pend <= do_read;
            fail_pulse <= miscompare;
            expired <= running & step & both_exp;
            if (read_pend) compare_reg <= array_read_data_in;
            if (state == st_idle && step && cmd[`CMD_ADDR_RESET]) begin
                fail_bits <= '0;
                fail_sticky <= 1'b0;
            end else if (miscompare) begin
                fail_bits <= fail_bits | enables;
                fail_sticky <= 1'b1;
            end
            // First failure captures the log; shifting drains it
            if (miscompare && !logged) begin
                logged <= 1'b1;
                log_sr <= pack_log(enables, icache_tag_cs_out | dcache_tag_cs_out,
                                   expect_word[3:0], xaddr, yaddr, mask);
            end else if (datalog_shift_in && step) begin
                log_sr <= {serial_test_in, log_sr[$bits(log_sr)-1:1]};
            end else if (dshift_d && !datalog_shift_in) begin
                logged <= 1'b0; // Release of the shift clears the log
                log_sr <= '0;
            end
        end
    end

    // Instruction chain; completion overwrites the enables with fail bits
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            instr <= '0;
            log_mode <= 1'b0;
        end else if (state == st_run && next_state == st_done) begin
            instr[`ENABLE_LSB +: `ENABLE_W] <= fail_bits & CONNECTED;
        end else if (step && instruction_shift_in) begin
            instr <= {cmd[`CMD_ADDR_INC], instr[`INSTR_LEN-1:1]};
        end else if (step && state == st_idle) begin
            log_mode <= (opcode == `OP_READ_LOG);
        end
    end

    // Serial output: fail log after a read-log opcode or while the datalog shifts, else instruction bits
    wire serial_out = (log_mode || datalog_shift_in) ? log_sr[0] : instr[0];
    wire expire_bit = instruction_shift_in || datalog_shift_in ? serial_out : expired;
    wire stall_bit = (state == st_stall) | (bitmap & do_read);
    wire fail_bit = pulse_mode ? fail_pulse : fail_sticky;
    wire [2:0] ret = {fail_bit, stall_bit, expire_bit};
    wire cache_side = |enables[`EN_XLAT:`EN_ICDATA];

    assign cache_unit_return_bus_out = cache_side ? ret : 3'h0;
    assign tcm_unit_return_bus_out = |enables[`EN_DTCM:`EN_ITCM] ? ret : 3'h0;
    assign test_status_out = {fail_bit, state == st_done, expired};

    // Checks
    expire_rule_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        expired |-> $past(both_exp) && $past(running))
        else $error("expire without both counters");
    scan_cs_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        scan_shift_enable_in |-> !xlat_cs_out && !write_out && icache_data_cs_out == 4'h0
        && dtcm_cs_out == 2'h0)
        else $error("select active during scan shift");
    bypass_mux_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        ram_bypass_select_in |-> cache_read_data_out == compare_reg[`DATA_W-1:0])
        else $error("bypass path not selected");
    sticky_fail_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        fail_sticky && !pulse_mode && state != st_idle |=> test_status_out[2])
        else $error("sticky fail dropped");
    pulse_fail_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        pulse_mode && miscompare |=> test_status_out[2])
        else $error("fail pulse missing");
    done_status_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        state == st_run && next_state == st_done |=> test_status_out[1])
        else $error("completion not shown");
    gate_hold_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        !step |=> $stable(xaddr) && $stable(yaddr))
        else $error("counter moved without gate");
    stall_hold_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        state == st_stall && logged |-> cache_unit_return_bus_out[1] || !cache_side)
        else $error("stall released early");
    mask_en_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (enables & ~CONNECTED) == '0)
        else $error("unconnected enable live");
endmodule : memory_bist_dispatch_unit
